// [hw/flash_erase_pkg.sv]
// Purpose: Shared constants and types for the flash erase and lock control block
// Assumes: 16-bit command bus, one write per command cycle
// Notes:   Command codes and timing figures are plain defaults
package flash_erase_pkg;
    localparam int          DATA_W          = 16;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0]  CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0]  CMD_SUSPEND     = 8'hB0;
    localparam logic [7:0]  CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
    localparam logic [7:0]  CMD_READ_ID     = 8'h90;
    localparam logic [7:0]  CMD_READ_QUERY  = 8'h98;
    localparam logic [7:0]  CMD_CLEAR_STAT  = 8'h50;
    localparam logic [7:0]  CMD_PROGRAM     = 8'h40;
    localparam logic [7:0]  CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0]  CMD_BUF_PROGRAM = 8'hE8;
    localparam logic [7:0]  CMD_LOCK_SETUP  = 8'h60;
    localparam logic [7:0]  CMD_LOCK        = 8'h01;
    localparam logic [7:0]  CMD_UNLOCK      = 8'hD0;
    localparam logic [7:0]  CMD_LOCK_DOWN   = 8'h2F;
    localparam logic [7:0]  CMD_SET_RCR     = 8'h03;
    localparam logic [7:0]  STATUS_RESET    = 8'h80;
    localparam int          ST_BUSY_BLOCK   = 0;
    localparam int          ST_LOCKED       = 1;
    localparam int          ST_SUPPLY       = 3;
    localparam int          ST_SEQ          = 4;
    localparam int          ST_ERASE_FAIL   = 5;
    localparam int          ST_SUSPENDED    = 6;
    localparam int          ST_READY        = 7;
    localparam int          ID_LOCK_BIT     = 0;
    localparam int          ID_DOWN_BIT     = 1;
    localparam logic [7:0]  UPPER_ZERO      = 8'h00;
    localparam int          CLK_MHZ         = 100;
    localparam int          ERASE_TIME_US   = 1000;
    localparam int          ERASE_CYCLES    = ERASE_TIME_US * CLK_MHZ;
    localparam int          CHECKPOINT_TIME_NS = 20;
    localparam int          CHECKPOINT_CYCLES  = (CHECKPOINT_TIME_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_ID, RD_QUERY} read_mode_t;
    typedef enum logic [2:0] {WSM_IDLE, WSM_ERASE, WSM_SUSP_REQ, WSM_SUSPENDED,
                              WSM_PROG_IN_SUSP} wsm_state_t;
endpackage

// [hw/lock_bus_if.sv]
// Purpose: Carries lock-bit accesses between the controller and the lock memory
// Assumes: One write port and one read port
// Notes:   Read data comes one cycle after the address
`timescale 1ns/1ns
`default_nettype none
interface lock_bus_if #(parameter int BLK_W = 6);
    logic [BLK_W-1:0] wrAddr;
    logic             wrEn;
    logic [1:0]       wrData;
    logic [BLK_W-1:0] rdAddr;
    logic [1:0]       rdData;
    logic             clearAll;
    modport ctrl (output wrAddr, output wrEn, output wrData, output rdAddr,
                  output clearAll, input rdData);
    modport mem  (input wrAddr, input wrEn, input wrData, input rdAddr,
                  input clearAll, output rdData);
endinterface
`default_nettype wire

// [hw/lock_bit_mem.sv]
// Purpose: Per-block lock and lock-down bits with registered read port
// Assumes: Reset clears to locked, not locked-down
// Notes:   Bit 0 is lock, bit 1 is lock-down
`timescale 1ns/1ns
`default_nettype none
module lock_bit_mem #(
    parameter int BLOCKS = 64,
    parameter int BLK_W  = 6
) (
    input  wire logic mclk,
    input  wire logic rst,
    lock_bus_if.mem   lb
);
    logic [1:0] bits_r [BLOCKS];
    logic [1:0] rdData_r;

    always_ff @(posedge mclk) begin
        if (rst || lb.clearAll) begin
            for (int i = 0; i < BLOCKS; i++) begin
                bits_r[i] <= 2'h1;
            end
        end else if (lb.wrEn) begin
            bits_r[lb.wrAddr] <= lb.wrData;
        end
        if (rst) begin
            rdData_r <= 2'h1;
        end else begin
            rdData_r <= bits_r[lb.rdAddr];
        end
    end
    assign lb.rdData = rdData_r;
endmodule
`default_nettype wire

// [hw/flash_block_erase_and_lock_control.sv]
// Purpose: Command decoder and erase sequencer with per-block locking
// Assumes: Host writes are single-cycle pulses on the device clock
// Notes:   Array cells are outside; this block issues erase pulses, program starts and program suspend requests only
// Behaviour
// - Each erase command erases exactly one whole block to all ones.
// - Chip select released mid-erase still lets the erase finish first.
// - Reads show status after erase; bit0 block busy, bit7 done.
// - Bit5 on erase failure; bit1 and abort when block is locked.
// - Low program supply halts erase and sets bit3; blocks all erasure.
// - Suspend accepted anywhere while erasing; sets bits 7 and 6 at checkpoint.
// - In suspend, reads and programming allowed except in suspended block.
// - Resume waits until any program started in suspend has finished.
// - Only listed commands accepted during erase suspend.
// - In suspend, chip select release gives standby; reset pin resets.
// - Resume at any address restarts erase from the full erase count and clears bits 7 and 6.
// - All blocks locked at power-up and after reset.
// - Locked blocks refuse program and erase (program in suspend is not lock-checked); lock changes are immediate.
// - Lock setup then lock locks block; set-config loads config register.
// - Lock setup with bad follower sets bits 4 and 5, kept over resume.
// - Lock bits work whatever the program supply level.
// - Lock-down blocks refuse erase; unlock only with write protect released.
// - Identifier reads give lock bit on data0, lock-down bit on data1.
// - Locking suspended block is immediate; lock refused in program suspend.
// - Status resets to 0x80; bit7 ready, clear means busy.
// - Status reads put status on low byte, zero on upper byte.
`timescale 1ns/1ns
`default_nettype none
module flash_block_erase_and_lock_control
    import flash_erase_pkg::*;
#(
    parameter int BLK_W        = 6,
    parameter int BLOCKS       = 64,
    parameter int ERASE_COUNT  = ERASE_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              deviceResetN,
    input  wire logic              chipSelectN,
    input  wire logic              writeProtectN,
    input  wire logic              supplyOk,
    input  wire logic              supplyLow,
    input  wire logic              cmdWrite,
    input  wire logic [BLK_W-1:0]  cmdBlock,
    input  wire logic [DATA_W-1:0] cmdData,
    input  wire logic [BLK_W-1:0]  readBlock,
    input  wire logic              progDone,
    input  wire logic              progFail,
    input  wire logic              eraseVerifyFail,
    output logic [DATA_W-1:0]      readData,
    output logic                   readIsArray,
    output logic                   eraseActive,
    output logic [BLK_W-1:0]       eraseBlock,
    output logic                   progStart,
    output logic [BLK_W-1:0]       progBlock,
    output logic                   progSuspendReq,
    output logic [DATA_W-1:0]      readConfig,
    output logic                   standby
);
    // Pin-level inputs pass two flops first
    logic [1:0] rstSync_r, csSync_r, wpSync_r, okSync_r, lowSync_r;
    always_ff @(posedge mclk) begin
        rstSync_r <= {rstSync_r[0], ~deviceResetN};
        csSync_r  <= {csSync_r[0], chipSelectN};
        wpSync_r  <= {wpSync_r[0], writeProtectN};
        okSync_r  <= {okSync_r[0], supplyOk};
        lowSync_r <= {lowSync_r[0], supplyLow};
    end
    logic resetAll, csHigh, wpHigh, supplyGood, supplyZero;
    assign resetAll   = rst || rstSync_r[1];
    assign csHigh     = csSync_r[1];
    assign wpHigh     = wpSync_r[1];
    assign supplyGood = okSync_r[1];
    assign supplyZero = lowSync_r[1];

    lock_bus_if #(.BLK_W(BLK_W)) lb ();
    lock_bit_mem #(.BLOCKS(BLOCKS), .BLK_W(BLK_W)) u_locks (
        .mclk (mclk),
        .rst  (rst),
        .lb   (lb)
    );

    wsm_state_t        state_r, state_nxt;
    read_mode_t        mode_r, mode_nxt;
    logic [7:0]        status_r, status_nxt;
    logic              lockSetup_r, lockSetup_nxt;
    logic              eraseSetup_r, eraseSetup_nxt;
    logic [BLK_W-1:0]  eraseBlock_r, eraseBlock_nxt;
    logic [BLK_W-1:0]  setupBlock_r, setupBlock_nxt;
    logic [31:0]       cnt_r, cnt_nxt;
    logic [DATA_W-1:0] rcr_r, rcr_nxt;
    logic              resumePend_r, resumePend_nxt;
    logic              progSusp_r, progSusp_nxt;
    logic [BLK_W-1:0]  progBlock_r, progBlock_nxt;
    logic              progStart_r, progStart_nxt;
    logic [DATA_W-1:0] readData_r, readData_nxt;
    logic              idRead_r;
    logic [BLK_W-1:0]  lbWrAddr;
    logic              lbWrEn;
    logic [1:0]        lbWrData;
    logic [7:0]        cmd;
    logic              prevSetup;

    function automatic logic blockProtected(input logic [1:0] bits);
        return bits[ID_LOCK_BIT] || bits[ID_DOWN_BIT];
    endfunction

    function automatic logic validInSuspend(input logic [7:0] c);
        return c == CMD_READ_ARRAY || c == CMD_READ_STATUS || c == CMD_READ_ID ||
               c == CMD_READ_QUERY || c == CMD_CONFIRM || c == CMD_CLEAR_STAT ||
               c == CMD_PROGRAM || c == CMD_PROGRAM_ALT || c == CMD_BUF_PROGRAM ||
               c == CMD_SUSPEND || c == CMD_LOCK_SETUP;
    endfunction

    assign cmd = cmdData[7:0];
    assign prevSetup = lockSetup_r || eraseSetup_r;

    // Lock bits of the command block are read for the erase check;
    // identifier reads use the read address on the cycle after
    assign lb.rdAddr   = idRead_r ? readBlock : setupBlock_r;
    assign lb.wrAddr   = lbWrAddr;
    assign lb.wrEn     = lbWrEn;
    assign lb.wrData   = lbWrData;
    assign lb.clearAll = rstSync_r[1];

    always_comb begin
        state_nxt      = state_r;
        mode_nxt       = mode_r;
        status_nxt     = status_r;
        lockSetup_nxt  = lockSetup_r && !cmdWrite;
        eraseSetup_nxt = eraseSetup_r;
        eraseBlock_nxt = eraseBlock_r;
        setupBlock_nxt = setupBlock_r;
        cnt_nxt        = cnt_r;
        rcr_nxt        = rcr_r;
        resumePend_nxt = resumePend_r;
        progSusp_nxt   = progSusp_r;
        progBlock_nxt  = progBlock_r;
        progStart_nxt  = 1'b0;
        lbWrAddr       = cmdBlock;
        lbWrEn         = 1'b0;
        lbWrData       = 2'h0;

        if (cmdWrite && lockSetup_r) begin
            // Lock commands act at once, whatever the supply level
            if (progSusp_r) begin
                status_nxt[ST_SEQ] = 1'b1;
                status_nxt[ST_ERASE_FAIL] = 1'b1;
            end else if (cmd == CMD_LOCK) begin
                lbWrEn   = 1'b1;
                lbWrData = {lb.rdData[ID_DOWN_BIT], 1'b1};
            end else if (cmd == CMD_UNLOCK) begin
                if (!lb.rdData[ID_DOWN_BIT] || wpHigh) begin
                    lbWrEn   = 1'b1;
                    lbWrData = 2'h0;
                end
                // With lock-down active, unlock only when write protect is released
                if (lb.rdData[ID_DOWN_BIT] && !wpHigh) begin
                    lbWrEn   = 1'b0;
                end else begin
                    lbWrEn   = 1'b1;
                    lbWrData = 2'h0;
                end
            end else if (cmd == CMD_LOCK_DOWN) begin
                lbWrEn   = 1'b1;
                lbWrData = 2'h3;
            end else if (cmd == CMD_SET_RCR) begin
                rcr_nxt = cmdData;
            end else begin
                status_nxt[ST_SEQ] = 1'b1;
                status_nxt[ST_ERASE_FAIL] = 1'b1;
            end
            mode_nxt = RD_STATUS;
        end else if (cmdWrite && eraseSetup_r) begin
            eraseSetup_nxt = 1'b0;
            mode_nxt       = RD_STATUS;
            if (cmd == CMD_CONFIRM && state_r == WSM_IDLE) begin
                status_nxt[ST_READY] = 1'b0;
                eraseBlock_nxt = setupBlock_r;
                if (blockProtected(lb.rdData)) begin
                    status_nxt[ST_LOCKED] = 1'b1;
                    status_nxt[ST_READY]  = 1'b1;
                end else if (supplyZero || !supplyGood) begin
                    status_nxt[ST_SUPPLY] = 1'b1;
                    status_nxt[ST_READY]  = 1'b1;
                end else begin
                    state_nxt = WSM_ERASE;
                    cnt_nxt   = 32'(ERASE_COUNT);
                end
            end else begin
                status_nxt[ST_SEQ] = 1'b1;
                status_nxt[ST_ERASE_FAIL] = 1'b1;
            end
        end else if (cmdWrite) begin
            if (state_r == WSM_SUSPENDED && !validInSuspend(cmd)) begin
                mode_nxt = mode_r;
            end else if (cmd == CMD_READ_ARRAY) begin
                mode_nxt = RD_ARRAY;
            end else if (cmd == CMD_READ_STATUS) begin
                mode_nxt = RD_STATUS;
            end else if (cmd == CMD_READ_ID) begin
                mode_nxt = RD_ID;
            end else if (cmd == CMD_READ_QUERY) begin
                mode_nxt = RD_QUERY;
            end else if (cmd == CMD_CLEAR_STAT) begin
                status_nxt = status_r & STATUS_RESET;
                status_nxt[ST_SUSPENDED] = status_r[ST_SUSPENDED];
            end else if (cmd == CMD_LOCK_SETUP) begin
                lockSetup_nxt  = 1'b1;
                setupBlock_nxt = cmdBlock;
            end else if (cmd == CMD_ERASE_SETUP && state_r == WSM_IDLE) begin
                eraseSetup_nxt = 1'b1;
                setupBlock_nxt = cmdBlock;
            end else if (cmd == CMD_SUSPEND && state_r == WSM_ERASE) begin
                state_nxt = WSM_SUSP_REQ;
                mode_nxt  = RD_STATUS;
            end else if (cmd == CMD_SUSPEND && state_r == WSM_PROG_IN_SUSP) begin
                progSusp_nxt = 1'b1;
            end else if (cmd == CMD_CONFIRM && state_r == WSM_SUSPENDED) begin
                resumePend_nxt = 1'b1;
            end else if (cmd == CMD_CONFIRM && state_r == WSM_PROG_IN_SUSP) begin
                if (progSusp_r) begin
                    progSusp_nxt = 1'b0;
                end else begin
                    resumePend_nxt = 1'b1;
                end
            end else if ((cmd == CMD_PROGRAM || cmd == CMD_PROGRAM_ALT ||
                          cmd == CMD_BUF_PROGRAM) && state_r == WSM_SUSPENDED) begin
                mode_nxt = RD_STATUS;
                if (cmdBlock != eraseBlock_r) begin
                    state_nxt     = WSM_PROG_IN_SUSP;
                    progBlock_nxt = cmdBlock;
                    progStart_nxt = 1'b1;
                end
            end
        end

        unique case (state_r)
            WSM_IDLE: begin
            end
            WSM_ERASE, WSM_SUSP_REQ: begin
                // Erase ignores chip select; it runs on until done, a supply fault or the suspend checkpoint
                if (supplyZero || !supplyGood) begin
                    state_nxt = WSM_IDLE;
                    status_nxt[ST_SUPPLY] = 1'b1;
                    status_nxt[ST_READY]  = 1'b1;
                end else if (cnt_r <= 32'd1) begin
                    state_nxt = WSM_IDLE;
                    status_nxt[ST_READY] = 1'b1;
                    status_nxt[ST_ERASE_FAIL] = status_r[ST_ERASE_FAIL] || eraseVerifyFail;
                end else if (state_r == WSM_SUSP_REQ && cnt_r <= 32'(CHECKPOINT_CYCLES)) begin
                    state_nxt = WSM_SUSPENDED;
                    status_nxt[ST_READY]     = 1'b1;
                    status_nxt[ST_SUSPENDED] = 1'b1;
                    cnt_nxt = 32'(ERASE_COUNT);
                end else if (state_nxt == WSM_SUSP_REQ && cnt_r > 32'(CHECKPOINT_CYCLES)) begin
                    cnt_nxt = 32'(CHECKPOINT_CYCLES);
                end else begin
                    cnt_nxt = cnt_r - 32'd1;
                end
            end
            WSM_SUSPENDED: begin
                if (resumePend_r || resumePend_nxt) begin
                    state_nxt      = WSM_ERASE;
                    resumePend_nxt = 1'b0;
                    status_nxt[ST_READY]     = 1'b0;
                    status_nxt[ST_SUSPENDED] = 1'b0;
                end
            end
            WSM_PROG_IN_SUSP: begin
                if (progDone) begin
                    state_nxt    = WSM_SUSPENDED;
                    progSusp_nxt = 1'b0;
                    status_nxt[ST_SEQ] = status_nxt[ST_SEQ] || progFail;
                end
            end
        endcase
        if (eraseSetup_r && !cmdWrite) begin
            eraseSetup_nxt = 1'b1;
        end
    end

    // Read path: status, identifier lock bits, or zero in array and query modes
    always_comb begin
        readData_nxt = '0;
        unique case (mode_r)
            RD_STATUS: readData_nxt = {UPPER_ZERO, status_r[7:1],
                                       (state_r == WSM_ERASE || state_r == WSM_SUSP_REQ)
                                       && readBlock == eraseBlock_r};
            RD_ID:     readData_nxt = {{(DATA_W-2){1'b0}}, lb.rdData};
            RD_QUERY:  readData_nxt = '0;
            RD_ARRAY:  readData_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (resetAll) begin
            state_r      <= WSM_IDLE;
            mode_r       <= RD_ARRAY;
            status_r     <= STATUS_RESET;
            lockSetup_r  <= 1'b0;
            eraseSetup_r <= 1'b0;
            eraseBlock_r <= '0;
            setupBlock_r <= '0;
            cnt_r        <= '0;
            rcr_r        <= '0;
            resumePend_r <= 1'b0;
            progSusp_r   <= 1'b0;
            progBlock_r  <= '0;
            progStart_r  <= 1'b0;
            readData_r   <= '0;
            idRead_r     <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            mode_r       <= mode_nxt;
            status_r     <= status_nxt;
            lockSetup_r  <= lockSetup_nxt;
            eraseSetup_r <= eraseSetup_nxt;
            eraseBlock_r <= eraseBlock_nxt;
            setupBlock_r <= setupBlock_nxt;
            cnt_r        <= cnt_nxt;
            rcr_r        <= rcr_nxt;
            resumePend_r <= resumePend_nxt;
            progSusp_r   <= progSusp_nxt;
            progBlock_r  <= progBlock_nxt;
            progStart_r  <= progStart_nxt;
            readData_r   <= readData_nxt;
            idRead_r     <= (mode_nxt == RD_ID) && !lockSetup_nxt && !eraseSetup_nxt;
        end
    end

    assign readData       = readData_r;
    assign readIsArray    = (mode_r == RD_ARRAY);
    assign eraseActive    = (state_r == WSM_ERASE || state_r == WSM_SUSP_REQ);
    assign eraseBlock     = eraseBlock_r;
    assign progStart      = progStart_r;
    assign progBlock      = progBlock_r;
    assign progSuspendReq = progSusp_r;
    assign readConfig     = rcr_r;
    assign standby        = csHigh && !eraseActive && !prevSetup;
endmodule
`default_nettype wire

// [bench/flash_erase_sva.sv]
// Purpose: Port-level assertions for the erase and lock controller
// Assumes: ERASE_COUNT matches the bound instance
// Notes:   Program tracking lets a resume be checked against a pending program
`timescale 1ns/1ns
`default_nettype none
module flash_erase_sva
    import flash_erase_pkg::*;
#(
    parameter int BLK_W       = 6,
    parameter int ERASE_COUNT = 20
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              cmdWrite,
    input  wire logic [DATA_W-1:0] cmdData,
    input  wire logic              progStart,
    input  wire logic              progDone,
    input  wire logic [DATA_W-1:0] readData,
    input  wire logic              readIsArray,
    input  wire logic              eraseActive,
    input  wire logic [BLK_W-1:0]  eraseBlock,
    input  wire logic              standby
);
    localparam int EMAX = ERASE_COUNT + 8;
    logic progPend_r;
    logic progPend_nxt;
    always_comb progPend_nxt = progStart | (progPend_r & ~progDone);
    always_ff @(posedge mclk) progPend_r <= rst ? 1'b0 : progPend_nxt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_upper; readData[15:8] == UPPER_ZERO; endproperty
    a_upper: assert property (p_upper) else $error("upper read byte not zero");
    property p_arr; readIsArray && $past(readIsArray) |-> readData == 16'h0000; endproperty
    a_arr: assert property (p_arr) else $error("array mode read not zero");
    property p_blk; eraseActive && $past(eraseActive) |-> $stable(eraseBlock); endproperty
    a_blk: assert property (p_blk) else $error("erase block moved mid erase");
    property p_dur; $rose(eraseActive) |-> ##[1:EMAX] !eraseActive; endproperty
    a_dur: assert property (p_dur) else $error("erase never finished");
    property p_cs; eraseActive |-> !standby; endproperty
    a_cs: assert property (p_cs) else $error("standby during erase");
    property p_busy; $rose(eraseActive) |-> ##2 !readData[7]; endproperty
    a_busy: assert property (p_busy) else $error("ready shown while erasing");
    property p_susp;
        cmdWrite && cmdData[7:0] == CMD_SUSPEND && eraseActive |-> ##[1:6] !eraseActive;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not taken");
    property p_pend; progPend_r |-> !eraseActive; endproperty
    a_pend: assert property (p_pend) else $error("erase resumed over program");
endmodule
bind flash_block_erase_and_lock_control flash_erase_sva #(
    .BLK_W(BLK_W), .ERASE_COUNT(ERASE_COUNT)) sva (.*);
`default_nettype wire

// [bench/flash_host_model.sv]
// Purpose: Host side of the flash bus plus an array that answers programs
// Assumes: One command write takes two clock edges
// Notes:   Released bus lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module flash_host_model
    import flash_erase_pkg::*;
#(
    parameter int BLK_W = 6
) (
    input  wire logic              mclk,
    input  wire logic              progStart,
    output logic                   cmdWrite,
    output logic [BLK_W-1:0]       cmdBlock,
    output logic [DATA_W-1:0]      cmdData,
    output logic                   progDone,
    output logic                   progFail
);
    int progCnt = 0;
    initial begin
        cmdWrite = 1'b0;
        cmdBlock = '0;
        cmdData  = '0;
        progDone = 1'b0;
        progFail = 1'b0;
    end
    // Program finishes four cycles after it starts
    always @(posedge mclk) begin
        progDone <= (progCnt == 1);
        progCnt  <= progStart ? 4 : (progCnt > 0 ? progCnt - 1 : 0);
    end
    task automatic wr(input logic [7:0] cmd, input logic [BLK_W-1:0] blk);
        @(posedge mclk);
        cmdWrite <= 1'b1;
        cmdData  <= {8'h00, cmd};
        cmdBlock <= blk;
        @(posedge mclk);
        cmdWrite <= 1'b0;
        cmdData  <= ~{8'h00, cmd};
        cmdBlock <= ~blk;
    endtask
    task automatic erase(input logic [BLK_W-1:0] blk);
        wr(CMD_ERASE_SETUP, blk);
        wr(CMD_CONFIRM, blk);
    endtask
endmodule
`default_nettype wire

// [bench/flash_block_erase_and_lock_control_tb.sv]
// Purpose: Self-checking bench for the erase and lock controller
// Assumes: Erase count shortened to 20 cycles
// Notes:   Random lock traffic among fixed corner cases
`timescale 1ns/1ns
`default_nettype none
module flash_block_erase_and_lock_control_tb;
    import flash_erase_pkg::*;
    localparam int BLK_W = 6;
    logic mclk = 1'b0, rst = 1'b1, deviceResetN = 1'b1, chipSelectN = 1'b0;
    logic writeProtectN = 1'b1, supplyOk = 1'b1, supplyLow = 1'b0, eraseVerifyFail = 1'b0;
    logic cmdWrite, progStart, progDone, progFail, readIsArray, eraseActive, standby;
    logic progSuspendReq, progSeen = 1'b0;
    logic [BLK_W-1:0] readBlock = '0, cmdBlock, eraseBlock, progBlock;
    logic [DATA_W-1:0] cmdData, readData, readConfig;
    logic lk [64];
    logic dn [64];
    int failures = 0, checksDone = 0;
    flash_block_erase_and_lock_control #(.BLK_W(BLK_W), .ERASE_COUNT(20)) dut (.*);
    flash_host_model #(.BLK_W(BLK_W)) host (.*);
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (progStart) progSeen <= 1'b1;
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic look(input logic [BLK_W-1:0] b, input logic [15:0] exp);
        readBlock <= b;
        repeat (4) @(posedge mclk);
        #1 chk(readData, exp);
    endtask
    task automatic resetModel;
        foreach (lk[i]) begin
            lk[i] = 1'b1;
            dn[i] = 1'b0;
        end
    endtask
    task automatic lockChk(input logic [7:0] c, input logic [BLK_W-1:0] b);
        host.wr(CMD_LOCK_SETUP, b);
        host.wr(c, b);
        if (c == CMD_LOCK || c == CMD_LOCK_DOWN) lk[b] = 1'b1;
        if (c == CMD_LOCK_DOWN) dn[b] = 1'b1;
        if (c == CMD_UNLOCK && (!dn[b] || writeProtectN)) begin
            lk[b] = 1'b0;
            dn[b] = 1'b0;
        end
        host.wr(CMD_READ_ID, b);
        look(b, {14'h0000, dn[b], lk[b]});
    endtask
    task automatic clr;
        host.wr(CMD_CLEAR_STAT, 6'h00);
        host.wr(CMD_READ_STATUS, 6'h00);
    endtask
    task automatic waitIdle;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 200 && eraseActive === 1'b1; i++) @(posedge mclk);
        chk({15'h0000, eraseActive}, 16'h0000);
    endtask
    initial begin
        resetModel();
        void'($urandom(84));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        host.wr(CMD_READ_STATUS, 6'h00);
        look(6'h00, {UPPER_ZERO, STATUS_RESET});
        host.erase(6'h07);
        look(6'h07, 16'h0082);
        clr();
        for (int i = 0; i < 12; i++) begin
            writeProtectN <= 1'($urandom);
            chipSelectN   <= 1'($urandom);
            lockChk($urandom % 2 ? CMD_LOCK : CMD_UNLOCK, BLK_W'($urandom));
        end
        writeProtectN <= 1'b1;
        lockChk(CMD_UNLOCK, 6'h09);
        chipSelectN <= 1'b1;
        host.erase(6'h09);
        look(6'h09, 16'h0001);
        look(6'h0A, 16'h0000);
        waitIdle();
        chk({15'h0000, standby}, 16'h0001);
        chipSelectN <= 1'b0;
        look(6'h09, 16'h0080);
        eraseVerifyFail <= 1'b1;
        host.erase(6'h09);
        waitIdle();
        eraseVerifyFail <= 1'b0;
        look(6'h09, 16'h00A0);
        clr();
        supplyOk <= 1'b0;
        supplyLow <= 1'b1;
        host.erase(6'h09);
        look(6'h09, 16'h0088);
        lockChk(CMD_LOCK, 6'h0B);
        supplyOk <= 1'b1;
        supplyLow <= 1'b0;
        clr();
        lockChk(CMD_UNLOCK, 6'h0C);
        host.erase(6'h09);
        repeat (4) @(posedge mclk);
        host.wr(CMD_SUSPEND, 6'h21);
        look(6'h09, 16'h00C0);
        chipSelectN <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({15'h0000, standby}, 16'h0001);
        chipSelectN <= 1'b0;
        host.wr(CMD_ERASE_SETUP, 6'h05);
        look(6'h09, 16'h00C0);
        lockChk(CMD_LOCK, 6'h09);
        host.wr(CMD_LOCK_SETUP, 6'h03);
        host.wr(CMD_READ_STATUS, 6'h03);
        host.wr(CMD_READ_STATUS, 6'h03);
        look(6'h09, 16'h00F0);
        host.wr(CMD_PROGRAM, 6'h0C);
        host.wr(8'h5A, 6'h0C);
        host.wr(CMD_CONFIRM, 6'h30);
        waitIdle();
        chk({15'h0000, progSeen}, 16'h0001);
        look(6'h09, 16'h00B0);
        clr();
        writeProtectN <= 1'b0;
        lockChk(CMD_LOCK_DOWN, 6'h0D);
        lockChk(CMD_UNLOCK, 6'h0D);
        clr();
        host.erase(6'h0D);
        look(6'h0D, 16'h0082);
        writeProtectN <= 1'b1;
        lockChk(CMD_UNLOCK, 6'h0D);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        resetModel();
        host.wr(CMD_READ_ID, 6'h0C);
        look(6'h0C, 16'h0001);
        lockChk(CMD_UNLOCK, 6'h0C);
        deviceResetN <= 1'b0;
        repeat (4) @(posedge mclk);
        deviceResetN <= 1'b1;
        repeat (4) @(posedge mclk);
        resetModel();
        host.wr(CMD_READ_ID, 6'h0C);
        look(6'h0C, 16'h0001);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
